// ===== emx_cfg.sv
`timescale 1ns/10ps
// Summary of operation
// - access control picks width, increment, write-only
// - pointer holds next expanded target location
// - data reads/writes reach pointed location
// - auto-increment advances pointer after each access
// - locations 8 bits; low byte maps
// - all-zero control means 8-bit read/write
// - location 0x1C0 bit 3 enables fallback
// - pointer is sixteen bits wide
// - strap low or bit 12 zero disables negotiation
// - duplex strap one full, zero half
// - speed strap 00/01/10 gives 10/100/1000
// - straps latched at reset, register overrides
// - master uses local clock, slave recovered at forced 1000 or with autoneg on, otherwise local
// - strap low slave, high master when autoneg strap low; otherwise role negotiated
// - gigabit control 12:11 overrides strapped role
// - same forced roles flag status bit 15
module emx_cfg #(
	parameter int EXP_ADDR_W = emx_pkg::EXP_ADDR_W
) (
	// clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	// power-on straps
	input  wire logic        AUTONEG_ENABLE_STRAP_IN,
	input  wire logic        DUPLEX_STRAP_IN,
	input  wire logic [1:0]  SPEED_STRAP_IN,
	input  wire logic        MASTER_STRAP_IN,
	// management register port
	input  wire logic [4:0]  MGMT_ADDR_IN,
	input  wire logic [15:0] MGMT_WDATA_IN,
	input  wire logic        MGMT_WR_IN,
	input  wire logic        MGMT_RD_IN,
	output logic      [15:0] MGMT_RDATA_OUT,
	output logic             MGMT_RVALID_OUT,
	output logic             MGMT_BUSY_OUT,
	// link status inputs
	input  wire logic        AN_RESOLVED_MASTER_IN,
	input  wire logic        LP_MANUAL_ROLE_IN,
	input  wire logic        LP_MANUAL_MASTER_IN,
	// configuration outputs
	output logic             AUTONEG_ENABLE_OUT,
	output logic             POWER_DOWN_OUT,
	output logic             FULL_DUPLEX_OUT,
	output logic [1:0]       FORCED_SPEED_OUT,
	output logic             MASTER_OUT,
	output logic             TX_CLK_RECOVERED_OUT,
	output logic             SPEED_FALLBACK_EN_OUT
);

	// ****************************************************************
	// state
	// ****************************************************************
	emx_pkg::emx_state_e   state;
	emx_pkg::emx_state_e   next_state;
	logic [15:0]           basic_control;
	logic [15:0]           next_basic_control;
	logic [15:0]           gigabit_control;
	logic [15:0]           next_gigabit_control;
	logic [15:0]           access_ctrl;
	logic [15:0]           next_access_ctrl;
	logic [15:0]           exp_ptr;
	logic [15:0]           next_exp_ptr;
	logic [15:0]           exp_data;
	logic [15:0]           next_exp_data;
	logic                  ms_fault;
	logic                  next_ms_fault;
	logic                  fallback_en;
	logic                  next_fallback_en;
	logic [15:0]           next_rdata;
	logic                  next_rvalid;
	logic                  next_busy;
	logic                  next_master;
	logic                  next_tx_recovered;
	logic                  mem_wr;
	logic                  mem_rd;
	logic [15:0]           mem_addr16;
	logic [7:0]            mem_wdata;
	logic [7:0]            mem_rdata;
	logic [7:0]            rd_byte;
	logic                  fault_set;
	logic                  fault_clr;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// a pointer beyond the implemented memory drops writes and reads zero
	function automatic logic in_range(input logic [15:0] a);
		in_range = ((a >> EXP_ADDR_W) == 16'h0000);
	endfunction

	function automatic logic [15:0] after_access(input logic [15:0] p, input logic [15:0] ac);
		after_access = ac[emx_pkg::AC_AUTO_INC] ? p + 16'h0001 : p;
	endfunction

	function automatic logic [15:0] strap_basic(input logic an, input logic dup, input logic [1:0] spd);
		logic [15:0] v;
		v = emx_pkg::RST_ZERO16;
		v[emx_pkg::BC_AN_ENABLE] = an;
		v[emx_pkg::BC_DUPLEX]    = dup;
		v[emx_pkg::BC_SPEED_MSB] = spd[1];
		v[emx_pkg::BC_SPEED_LSB] = spd[0];
		strap_basic = v;
	endfunction

	// ****************************************************************
	// expanded memory
	// ****************************************************************
	emx_mem #(
		.DATA_W (8),
		.ADDR_W (EXP_ADDR_W)
	) u_mem (
		// contents are not cleared by reset
		.clk_in    (REF_CLK_IN),
		.rst_in    (RST_IN),
		.wr_in     (mem_wr),
		.rd_in     (mem_rd),
		.addr_in   (mem_addr16[EXP_ADDR_W-1:0]),
		.wdata_in  (mem_wdata),
		.rdata_out (mem_rdata)
	);

	// ****************************************************************
	// register access and expanded sequencer
	// ****************************************************************
	always_comb begin
		next_state           = state;
		next_basic_control   = basic_control;
		next_gigabit_control = gigabit_control;
		next_access_ctrl     = access_ctrl;
		next_exp_ptr         = exp_ptr;
		next_exp_data        = exp_data;
		next_rdata           = MGMT_RDATA_OUT;
		next_rvalid          = 1'b0;
		mem_wr               = 1'b0;
		mem_rd               = 1'b0;
		mem_addr16           = exp_ptr;
		mem_wdata            = exp_data[7:0];
		fault_clr            = 1'b0;
		rd_byte              = in_range(exp_ptr) ? mem_rdata : 8'h00;
		// a strobe that arrives while a sequence runs is dropped; busy shows it
		unique case (state)
			emx_pkg::ST_IDLE: begin
				if (MGMT_WR_IN) begin
					unique case (MGMT_ADDR_IN)
						emx_pkg::OFF_BASIC_CONTROL:   next_basic_control   = MGMT_WDATA_IN;
						emx_pkg::OFF_GIGABIT_CONTROL: next_gigabit_control = MGMT_WDATA_IN;
						emx_pkg::OFF_EXP_ACCESS_CTRL: next_access_ctrl = MGMT_WDATA_IN & emx_pkg::AC_MASK;
						emx_pkg::OFF_EXP_ADDR_PTR:    next_exp_ptr     = MGMT_WDATA_IN;
						emx_pkg::OFF_EXP_DATA: begin
							next_exp_data = MGMT_WDATA_IN;
							mem_wdata     = MGMT_WDATA_IN[7:0];
							mem_wr        = in_range(exp_ptr);
							if (access_ctrl[emx_pkg::AC_WIDE16]) begin
								next_state = emx_pkg::ST_WR_HI;
							end else begin
								next_exp_ptr = after_access(exp_ptr, access_ctrl);
							end
						end
						default: begin
						end
					endcase
				end else if (MGMT_RD_IN) begin
					if (MGMT_ADDR_IN == emx_pkg::OFF_EXP_DATA && !access_ctrl[emx_pkg::AC_WRITE_ONLY]) begin
						mem_rd     = 1'b1;
						next_state = emx_pkg::ST_RD_LO;
					end else begin
						// write-only mode answers from the held data register
						next_rvalid = 1'b1;
						unique case (MGMT_ADDR_IN)
							emx_pkg::OFF_BASIC_CONTROL:   next_rdata = basic_control;
							emx_pkg::OFF_GIGABIT_CONTROL: next_rdata = gigabit_control;
							emx_pkg::OFF_GIGABIT_STATUS: begin
								next_rdata = emx_pkg::RST_ZERO16;
								next_rdata[emx_pkg::GS_MS_FAULT] = ms_fault;
								fault_clr  = 1'b1;
							end
							emx_pkg::OFF_EXP_ACCESS_CTRL: next_rdata = access_ctrl;
							emx_pkg::OFF_EXP_ADDR_PTR:    next_rdata = exp_ptr;
							emx_pkg::OFF_EXP_DATA:        next_rdata = exp_data;
							default:                      next_rdata = emx_pkg::RST_ZERO16;
						endcase
					end
				end
			end
			emx_pkg::ST_WR_HI: begin
				// high byte goes to the next location; with auto-increment the pointer steps by one
				mem_addr16   = exp_ptr + 16'h0001;
				mem_wdata    = exp_data[15:8];
				mem_wr       = in_range(mem_addr16);
				next_exp_ptr = after_access(exp_ptr, access_ctrl);
				next_state   = emx_pkg::ST_IDLE;
			end
			emx_pkg::ST_RD_LO: begin
				next_exp_data = {8'h00, rd_byte};
				if (access_ctrl[emx_pkg::AC_WIDE16]) begin
					mem_addr16 = exp_ptr + 16'h0001;
					mem_rd     = 1'b1;
					next_state = emx_pkg::ST_RD_HI;
				end else begin
					next_rdata   = {8'h00, rd_byte};
					next_rvalid  = 1'b1;
					next_exp_ptr = after_access(exp_ptr, access_ctrl);
					next_state   = emx_pkg::ST_IDLE;
				end
			end
			emx_pkg::ST_RD_HI: begin
				rd_byte       = in_range(exp_ptr + 16'h0001) ? mem_rdata : 8'h00;
				next_exp_data = {rd_byte, exp_data[7:0]};
				next_rdata    = {rd_byte, exp_data[7:0]};
				next_rvalid   = 1'b1;
				next_exp_ptr  = after_access(exp_ptr, access_ctrl);
				next_state    = emx_pkg::ST_IDLE;
			end
			default: next_state = emx_pkg::ST_IDLE;
		endcase
		next_busy = (next_state != emx_pkg::ST_IDLE);
	end

	// ****************************************************************
	// fallback shadow, role and fault
	// ****************************************************************
	always_comb begin
		next_fallback_en = fallback_en;
		if (mem_wr && mem_addr16 == emx_pkg::EXP_FALLBACK_LOC) begin
			next_fallback_en = mem_wdata[emx_pkg::EXP_FALLBACK_BIT];
		end
		// manual role from register, otherwise negotiated role
		if (gigabit_control[emx_pkg::GC_MANUAL_MS]) begin
			next_master = gigabit_control[emx_pkg::GC_MS_MASTER];
		end else begin
			next_master = AN_RESOLVED_MASTER_IN;
		end
		// only a slave at forced speed 1000 or with autoneg enabled transmits on the recovered clock
		next_tx_recovered = 1'b0;
		if (FORCED_SPEED_OUT == emx_pkg::SPEED_1000 || basic_control[emx_pkg::BC_AN_ENABLE]) begin
			next_tx_recovered = !MASTER_OUT;
		end
		// both ends forced to one role can never resolve
		fault_set = 1'b0;
		if (gigabit_control[emx_pkg::GC_MANUAL_MS] && LP_MANUAL_ROLE_IN) begin
			fault_set = (LP_MANUAL_MASTER_IN == gigabit_control[emx_pkg::GC_MS_MASTER]);
		end
		// a fault seen during the clearing read survives it
		next_ms_fault = (ms_fault && !fault_clr) || fault_set;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			// straps are taken on every reset edge, so they must be stable then
			state           <= emx_pkg::ST_IDLE;
			basic_control   <= strap_basic(AUTONEG_ENABLE_STRAP_IN, DUPLEX_STRAP_IN, SPEED_STRAP_IN);
			gigabit_control <= emx_pkg::RST_ZERO16;
			gigabit_control[emx_pkg::GC_MANUAL_MS] <= !AUTONEG_ENABLE_STRAP_IN;
			gigabit_control[emx_pkg::GC_MS_MASTER] <= MASTER_STRAP_IN;
			access_ctrl     <= emx_pkg::RST_ACCESS_CTRL;
			exp_ptr         <= emx_pkg::RST_EXP_PTR;
			exp_data        <= emx_pkg::RST_EXP_DATA;
			ms_fault        <= 1'b0;
			fallback_en     <= 1'b0;
			MGMT_RDATA_OUT  <= emx_pkg::RST_ZERO16;
			MGMT_RVALID_OUT <= 1'b0;
			MGMT_BUSY_OUT   <= 1'b0;
			MASTER_OUT      <= 1'b0;
			TX_CLK_RECOVERED_OUT <= 1'b0;
		end else begin
			state           <= next_state;
			basic_control   <= next_basic_control;
			gigabit_control <= next_gigabit_control;
			access_ctrl     <= next_access_ctrl;
			exp_ptr         <= next_exp_ptr;
			exp_data        <= next_exp_data;
			ms_fault        <= next_ms_fault;
			fallback_en     <= next_fallback_en;
			MGMT_RDATA_OUT  <= next_rdata;
			MGMT_RVALID_OUT <= next_rvalid;
			MGMT_BUSY_OUT   <= next_busy;
			MASTER_OUT      <= next_master;
			TX_CLK_RECOVERED_OUT <= next_tx_recovered;
		end
	end

	// ****************************************************************
	// configuration outputs straight from register bits
	// ****************************************************************
	assign AUTONEG_ENABLE_OUT    = basic_control[emx_pkg::BC_AN_ENABLE];
	assign POWER_DOWN_OUT        = basic_control[emx_pkg::BC_POWER_DN];
	assign FULL_DUPLEX_OUT       = basic_control[emx_pkg::BC_DUPLEX];
	assign FORCED_SPEED_OUT      = {basic_control[emx_pkg::BC_SPEED_MSB], basic_control[emx_pkg::BC_SPEED_LSB]};
	assign SPEED_FALLBACK_EN_OUT = fallback_en;

endmodule

// ===== emx_pkg.sv
package emx_pkg;

	// ****************************************************************
	// management register offsets
	// ****************************************************************
	localparam logic [4:0] OFF_BASIC_CONTROL   = 5'h00;
	localparam logic [4:0] OFF_GIGABIT_CONTROL = 5'h09;
	localparam logic [4:0] OFF_GIGABIT_STATUS  = 5'h0A;
	localparam logic [4:0] OFF_EXP_ACCESS_CTRL = 5'h16;
	localparam logic [4:0] OFF_EXP_DATA        = 5'h1D;
	localparam logic [4:0] OFF_EXP_ADDR_PTR    = 5'h1E;

	// ****************************************************************
	// basic control fields
	// ****************************************************************
	localparam int BC_SPEED_LSB = 13;
	localparam int BC_AN_ENABLE = 12;
	localparam int BC_POWER_DN  = 11;
	localparam int BC_DUPLEX    = 8;
	localparam int BC_SPEED_MSB = 6;

	// ****************************************************************
	// gigabit control and status fields
	// ****************************************************************
	localparam int GC_MANUAL_MS  = 12;
	localparam int GC_MS_MASTER  = 11;
	localparam int GS_MS_FAULT   = 15;

	// ****************************************************************
	// expanded access control fields
	// ****************************************************************
	localparam int             AC_WIDE16     = 0;
	localparam int             AC_AUTO_INC   = 1;
	localparam int             AC_WRITE_ONLY = 2;
	localparam logic [15:0]    AC_MASK       = 16'h0007;

	// ****************************************************************
	// expanded memory
	// ****************************************************************
	localparam int             EXP_ADDR_W       = 9;
	localparam logic [15:0]    EXP_FALLBACK_LOC = 16'h01C0;
	localparam int             EXP_FALLBACK_BIT = 3;

	// ****************************************************************
	// forced speed codes
	// ****************************************************************
	localparam logic [1:0]     SPEED_10   = 2'h0;
	localparam logic [1:0]     SPEED_100  = 2'h1;
	localparam logic [1:0]     SPEED_1000 = 2'h2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0]    RST_ACCESS_CTRL = 16'h0000;
	localparam logic [15:0]    RST_EXP_DATA    = 16'h0000;
	localparam logic [15:0]    RST_EXP_PTR     = 16'h0000;
	localparam logic [15:0]    RST_ZERO16      = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_HI,
		ST_RD_LO,
		ST_RD_HI
	} emx_state_e;

endpackage

// ===== emx_mem.sv
`timescale 1ns/10ps
module emx_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 9
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// access
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	output logic      [DATA_W-1:0] rdata_out
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = rdata_out;
		if (rd_in) begin
			next_rdata = mem[addr_in];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= next_rdata;
		end
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

endmodule

// ===== emx_mgmt_model.sv
`timescale 1ns/10ps
module emx_mgmt_model (
	// register port answer
	input  wire logic        clk_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in,
	input  wire logic        busy_in,
	// register port request
	output logic      [4:0]  addr_out,
	output logic      [15:0] wdata_out,
	output logic             wr_out,
	output logic             rd_out
);
	initial begin
		addr_out  = 5'h1F;
		wdata_out = 16'h0000;
		wr_out    = 1'b0;
		rd_out    = 1'b0;
	end
	// ****
	// requests: one idle cycle first, released lines inverted
	// ****
	task automatic go(input logic [4:0] a, input logic [15:0] d, input logic w);
		int n;
		n = 0;
		@(posedge clk_in);
		#1;
		while (busy_in && n < 16) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		addr_out  = a;
		wdata_out = d;
		wr_out    = w;
		rd_out    = !w;
		@(posedge clk_in);
		#1;
		wr_out    = 1'b0;
		rd_out    = 1'b0;
		addr_out  = ~a;
		wdata_out = ~d;
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		go(a, d, 1'b1);
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] q);
		int n;
		n = 0;
		go(a, 16'h0000, 1'b0);
		while (!rvalid_in && n < 8) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		q = rvalid_in ? rdata_in : 16'hXXXX;
	endtask
endmodule

// ===== emx_cfg_properties.sv
`timescale 1ns/10ps
module emx_cfg_properties (
	// watched ports
	input wire logic        REF_CLK_IN,
	input wire logic        RST_IN,
	input wire logic [4:0]  MGMT_ADDR_IN,
	input wire logic [15:0] MGMT_WDATA_IN,
	input wire logic        MGMT_WR_IN,
	input wire logic        MGMT_RD_IN,
	input wire logic        MGMT_RVALID_OUT,
	input wire logic        MGMT_BUSY_OUT,
	input wire logic        AUTONEG_ENABLE_OUT,
	input wire logic        FULL_DUPLEX_OUT,
	input wire logic [1:0]  FORCED_SPEED_OUT,
	input wire logic        MASTER_OUT,
	input wire logic        TX_CLK_RECOVERED_OUT
);
	logic prev_data;
	logic next_prev_data;
	logic idle;
	always_comb begin
		next_prev_data = (MGMT_WR_IN || MGMT_RD_IN) && MGMT_ADDR_IN == emx_pkg::OFF_EXP_DATA;
	end
	always_ff @(posedge REF_CLK_IN) begin
		prev_data <= next_prev_data;
	end
	assign idle = !MGMT_BUSY_OUT && !prev_data;
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RST_IN);
	sequence s_bc_wr;
		MGMT_WR_IN && idle && MGMT_ADDR_IN == emx_pkg::OFF_BASIC_CONTROL;
	endsequence
	sequence s_gc_manual;
		MGMT_WR_IN && idle && MGMT_ADDR_IN == emx_pkg::OFF_GIGABIT_CONTROL && MGMT_WDATA_IN[12];
	endsequence
	sequence s_gc_quiet;
		!(MGMT_WR_IN && MGMT_ADDR_IN == emx_pkg::OFF_GIGABIT_CONTROL);
	endsequence
	chk_autoneg_write: assert property (s_bc_wr |=> AUTONEG_ENABLE_OUT == $past(MGMT_WDATA_IN[12]))
		else $error("autoneg enable misses control write");
	chk_duplex_write: assert property (s_bc_wr |=> FULL_DUPLEX_OUT == $past(MGMT_WDATA_IN[8]))
		else $error("duplex misses control write");
	chk_speed_write: assert property (s_bc_wr |=> FORCED_SPEED_OUT == {$past(MGMT_WDATA_IN[6]), $past(MGMT_WDATA_IN[13])})
		else $error("speed misses control write");
	chk_manual_role: assert property (s_gc_manual ##1 s_gc_quiet |=> MASTER_OUT == $past(MGMT_WDATA_IN[11], 2))
		else $error("manual role not applied");
	chk_master_local_clk: assert property ($past(MASTER_OUT) |-> !TX_CLK_RECOVERED_OUT)
		else $error("master uses recovered clock");
	chk_reg_answer: assert property (MGMT_RD_IN && !MGMT_WR_IN && idle && MGMT_ADDR_IN != emx_pkg::OFF_EXP_DATA |=> MGMT_RVALID_OUT)
		else $error("register read unanswered");
	chk_data_answer: assert property (MGMT_RD_IN && !MGMT_WR_IN && idle && MGMT_ADDR_IN == emx_pkg::OFF_EXP_DATA |-> ##[1:3] MGMT_RVALID_OUT)
		else $error("data read unanswered");
	chk_busy_bound: assert property ($rose(MGMT_BUSY_OUT) |-> ##[1:2] !MGMT_BUSY_OUT)
		else $error("busy too long");
	chk_rvalid_pulse: assert property (MGMT_RVALID_OUT |=> !MGMT_RVALID_OUT)
		else $error("read valid longer than one cycle");
endmodule
bind emx_cfg emx_cfg_properties u_props (.REF_CLK_IN, .RST_IN, .MGMT_ADDR_IN, .MGMT_WDATA_IN, .MGMT_WR_IN, .MGMT_RD_IN,
	.MGMT_RVALID_OUT, .MGMT_BUSY_OUT, .AUTONEG_ENABLE_OUT, .FULL_DUPLEX_OUT, .FORCED_SPEED_OUT, .MASTER_OUT,
	.TX_CLK_RECOVERED_OUT);

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp_val;
	} emx_row_s;
	logic        clk, rst, an_s, dup_s, ms_s, wr, rd, rv, busy, anm, lpr, lpm, an_o, pd_o, fd_o, m_o, tx_o, fb_o;
	logic [1:0]  spd_s, sp_o;
	logic [4:0]  addr;
	logic [15:0] wd, rdat, q;
	int          err_count;
	int          comparisons;
	emx_row_s    rows [6];
	emx_cfg dut (.REF_CLK_IN(clk), .RST_IN(rst), .AUTONEG_ENABLE_STRAP_IN(an_s), .DUPLEX_STRAP_IN(dup_s),
		.SPEED_STRAP_IN(spd_s), .MASTER_STRAP_IN(ms_s), .MGMT_ADDR_IN(addr), .MGMT_WDATA_IN(wd), .MGMT_WR_IN(wr),
		.MGMT_RD_IN(rd), .MGMT_RDATA_OUT(rdat), .MGMT_RVALID_OUT(rv), .MGMT_BUSY_OUT(busy),
		.AN_RESOLVED_MASTER_IN(anm), .LP_MANUAL_ROLE_IN(lpr), .LP_MANUAL_MASTER_IN(lpm), .AUTONEG_ENABLE_OUT(an_o),
		.POWER_DOWN_OUT(pd_o), .FULL_DUPLEX_OUT(fd_o), .FORCED_SPEED_OUT(sp_o), .MASTER_OUT(m_o),
		.TX_CLK_RECOVERED_OUT(tx_o), .SPEED_FALLBACK_EN_OUT(fb_o));
	emx_mgmt_model mdl (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .busy_in(busy), .addr_out(addr),
		.wdata_out(wd), .wr_out(wr), .rd_out(rd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// ****
	// reset with given straps, then check what was latched
	// ****
	task automatic strap_case(input logic an, input logic dup, input logic [1:0] spd, input logic ms);
		an_s  = an;
		dup_s = dup;
		spd_s = spd;
		ms_s  = ms;
		rst   = 1'b1;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		settle();
		chk({15'h0000, an_o}, {15'h0000, an});
		chk({15'h0000, fd_o}, {15'h0000, dup});
		chk({14'h0000, sp_o}, {14'h0000, spd});
		chk({15'h0000, m_o}, {15'h0000, an ? anm : ms});
		chk({15'h0000, tx_o}, {15'h0000, (spd == 2'h2 || an) && !(an ? anm : ms)});
		mdl.rd_reg(5'h00, q);
		chk(q, {2'h0, spd[0], an, 3'h0, dup, 1'b0, spd[1], 6'h00});
		mdl.rd_reg(5'h09, q);
		chk(q, {3'h0, !an, ms, 11'h000});
	endtask
	initial begin
		err_count   = 0;
		comparisons = 0;
		anm = 1'b0;
		lpr = 1'b0;
		lpm = 1'b0;
		rows = '{'{5'h00, 16'h2140, 16'h2140}, '{5'h09, 16'h1800, 16'h1800}, '{5'h16, 16'hFFFF, 16'h0007},
			'{5'h1E, 16'hA5C3, 16'hA5C3}, '{5'h0A, 16'h1234, 16'h0000}, '{5'h05, 16'hFFFF, 16'h0000}};
		strap_case(1'b0, 1'b1, 2'h2, 1'b1);
		foreach (rows[i]) begin
			mdl.wr_reg(rows[i].addr, rows[i].wdata);
			mdl.rd_reg(rows[i].addr, q);
			chk(q, rows[i].exp_val);
		end
		// ****
		// fallback enable sequence, 8-bit no increment
		// ****
		mdl.wr_reg(5'h00, 16'h0800);
		mdl.wr_reg(5'h16, 16'h0000);
		chk({15'h0000, pd_o}, 16'h0001);
		mdl.wr_reg(5'h1E, 16'h01C0);
		mdl.wr_reg(5'h1D, 16'h0008);
		mdl.wr_reg(5'h00, 16'h0000);
		chk({15'h0000, fb_o}, 16'h0001);
		mdl.rd_reg(5'h1E, q);
		chk(q, 16'h01C0);
		mdl.wr_reg(5'h1D, 16'h00F7);
		chk({15'h0000, fb_o}, 16'h0000);
		// ****
		// auto increment, reload before verify
		// ****
		mdl.wr_reg(5'h16, 16'h0002);
		mdl.wr_reg(5'h1E, 16'h0010);
		mdl.wr_reg(5'h1D, 16'hAB55);
		mdl.wr_reg(5'h1D, 16'h0066);
		mdl.rd_reg(5'h1E, q);
		chk(q, 16'h0012);
		mdl.wr_reg(5'h1E, 16'h0010);
		mdl.rd_reg(5'h1D, q);
		chk(q, 16'h0055);
		mdl.rd_reg(5'h1D, q);
		chk(q, 16'h0066);
		mdl.rd_reg(5'h1E, q);
		chk(q, 16'h0012);
		// ****
		// 16-bit mode, then write-only mode
		// ****
		mdl.wr_reg(5'h16, 16'h0003);
		mdl.wr_reg(5'h1E, 16'h0020);
		mdl.wr_reg(5'h1D, 16'hBEEF);
		mdl.wr_reg(5'h1E, 16'h0020);
		mdl.rd_reg(5'h1D, q);
		chk(q, 16'hBEEF);
		mdl.rd_reg(5'h1E, q);
		chk(q, 16'h0021);
		mdl.wr_reg(5'h16, 16'h0000);
		mdl.rd_reg(5'h1D, q);
		chk(q, 16'h00BE);
		mdl.wr_reg(5'h16, 16'h0004);
		mdl.rd_reg(5'h1D, q);
		chk(q, 16'h00BE);
		mdl.rd_reg(5'h1E, q);
		chk(q, 16'h0021);
		// ****
		// forced role conflict and transmit clock source
		// ****
		mdl.wr_reg(5'h00, 16'h0040);
		mdl.wr_reg(5'h09, 16'h1800);
		lpr = 1'b1;
		lpm = 1'b1;
		settle();
		chk({15'h0000, m_o}, 16'h0001);
		chk({15'h0000, tx_o}, 16'h0000);
		mdl.rd_reg(5'h0A, q);
		chk({15'h0000, q[15]}, 16'h0001);
		lpm = 1'b0;
		mdl.rd_reg(5'h0A, q);
		mdl.rd_reg(5'h0A, q);
		chk({15'h0000, q[15]}, 16'h0000);
		lpr = 1'b0;
		mdl.wr_reg(5'h09, 16'h1000);
		settle();
		chk({15'h0000, m_o}, 16'h0000);
		chk({15'h0000, tx_o}, 16'h0001);
		anm = 1'b1;
		strap_case(1'b1, 1'b0, 2'h1, 1'b0);
		close_out();
	end
	initial begin
		#200000;
		err_count++;
		close_out();
	end
endmodule
